// ==== core/wss_search.sv ====
// Wakeup search control: monitor sequencing, pass/fail decision, status snapshot
`timescale 1ns/1ps

module wss_search (
    input wire logic i_clock,
    input wire logic i_srst,
    // Search control
    input wire logic i_search_start,
    input wire logic i_search_mode,
    input wire logic i_init_acq_en,
    input wire logic [1:0] i_slicer_preload_select,
    input wire logic [5:0] i_monitor_select_mask,
    input wire logic [5:0] i_search_timeout_count,
    input wire logic i_bit_tick,
    input wire logic i_chip_timeout,
    // Monitor results
    input wire logic [5:0] i_mon_valid,
    input wire logic [5:0] i_mon_error,
    input wire logic [7:0] i_signal_level,
    // Host serial interface events and sampling control
    input wire logic i_read_cmd,
    input wire logic i_read_level_reg,
    input wire logic i_sor_write,
    input wire logic i_sor_wdata,
    input wire logic i_manual_sampling,
    // Monitor resets and slicer state
    output logic o_rst_timer,
    output logic o_rst_amplitude,
    output logic o_rst_slicer,
    output logic o_rst_chip_code,
    output logic o_rst_baud,
    output logic o_slicer_acq,
    output logic o_slicer_valid,
    // Search result
    output logic o_search_busy,
    output logic o_irq,
    output logic o_search_failed_flag,
    // Snapshot registers
    output logic [5:0] o_monitor_valid_status,
    output logic [5:0] o_monitor_error_status,
    output logic [7:0] o_signal_level_status,
    output logic o_sample_on_read
);

    wss_pkg::wss_regs_t r;
    wss_pkg::wss_regs_t n;

    logic [5:0] live_valid;
    logic [5:0] live_error;
    logic [5:0] pass_w;
    logic [5:0] fail_w;
    logic all_pass;
    logic any_fail;
    logic end_w;
    logic sample_w;
    logic restart_w;
    logic timer_on;

    // Live monitor state; the timer takes the top position
    always_comb begin
        live_valid = i_mon_valid;
        live_error = i_mon_error;
        live_valid[wss_pkg::MON_TIMER] = r.texp;
        live_error[wss_pkg::MON_TIMER] = r.texp;
    end

    // Pass/fail terms toward the decision
    always_comb begin
        for (int i = 0; i < wss_pkg::MON_W; i++) begin
            if (!i_monitor_select_mask[i]) begin
                pass_w[i] = 1'b1;
                fail_w[i] = 1'b0;
            end else begin
                pass_w[i] = i_mon_valid[i] & ~i_mon_error[i];
                fail_w[i] = i_mon_valid[i] & i_mon_error[i];
            end
        end
        // Timer never blocks success; it only forces failure in mode 2
        pass_w[wss_pkg::MON_TIMER] = 1'b1;
        fail_w[wss_pkg::MON_TIMER] = i_search_mode & r.texp;
    end

    assign all_pass = &pass_w;
    assign any_fail = |fail_w;
    assign end_w = r.busy & ~i_search_start & (all_pass | any_fail);
    assign sample_w = end_w | (i_read_cmd & r.sor);
    assign restart_w = i_search_mode & i_init_acq_en & i_chip_timeout;
    assign timer_on = i_search_timeout_count != wss_pkg::TIMEOUT_OFF;

    always_comb begin
        n = r;
        n.irq = 1'b0;
        n.rst_tmr = 1'b0;
        n.rst_amp = 1'b0;
        n.rst_sl = 1'b0;
        if (i_search_start) begin
            n.busy = 1'b1;
            n.rst_tmr = 1'b1;
            n.rst_amp = 1'b1;
            n.rst_sl = i_slicer_preload_select != wss_pkg::PRELOAD_NONE;
            n.pre = 4'h0;
            n.tmr = 6'h00;
            n.texp = 1'b0;
            n.bitcnt = 2'h0;
            n.slv = ~i_init_acq_en;
            n.st = i_init_acq_en ? wss_pkg::WSS_ACQ : wss_pkg::WSS_RUN;
        end else begin
            case (r.st)
                wss_pkg::WSS_ACQ: begin
                    if (i_bit_tick) begin
                        n.bitcnt = r.bitcnt + 2'h1;
                        if (r.bitcnt == wss_pkg::ACQ_BITS - 2'h1) begin
                            n.st = wss_pkg::WSS_RUN;
                            n.slv = 1'b1;
                        end
                    end
                end
                wss_pkg::WSS_RUN: begin
                    if (restart_w) begin
                        n.st = wss_pkg::WSS_ACQ;
                        n.bitcnt = 2'h0;
                        n.slv = 1'b0;
                        n.rst_sl = i_slicer_preload_select != wss_pkg::PRELOAD_NONE;
                    end
                end
                wss_pkg::WSS_IDLE: begin
                    n.st = wss_pkg::WSS_IDLE;
                end
                default: begin
                    n.st = wss_pkg::WSS_IDLE;
                end
            endcase
            // Search timer runs in both modes so its status is always reported
            if (r.busy && timer_on && !r.texp && i_bit_tick) begin
                if (r.pre == wss_pkg::UNIT_BITS - 4'h1) begin
                    n.pre = 4'h0;
                    n.tmr = r.tmr + 6'h01;
                    if (r.tmr + 6'h01 == i_search_timeout_count) begin
                        n.texp = 1'b1;
                    end
                end else begin
                    n.pre = r.pre + 4'h1;
                end
            end
            if (end_w) begin
                n.st = wss_pkg::WSS_IDLE;
                n.busy = 1'b0;
                n.irq = 1'b1;
                n.fail = any_fail;
            end
        end
        // Checkers stay in reset for the whole acquisition phase
        n.rst_cc = i_search_start | (n.st == wss_pkg::WSS_ACQ);
        // All three words are captured together; errors masked by validity
        if (sample_w) begin
            n.vst = live_valid;
            n.est = live_valid & live_error;
            n.lvl = i_signal_level;
        end
        if (end_w) begin
            n.sor = 1'b0;
        end else if (i_sor_write) begin
            n.sor = i_sor_wdata;
        end else if (i_read_level_reg && !i_manual_sampling) begin
            n.sor = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            r.st <= wss_pkg::WSS_IDLE;
            r.bitcnt <= 2'h0;
            r.pre <= 4'h0;
            r.tmr <= 6'h00;
            r.texp <= 1'b0;
            r.busy <= 1'b0;
            r.rst_tmr <= 1'b0;
            r.rst_amp <= 1'b0;
            r.rst_sl <= 1'b0;
            r.rst_cc <= 1'b0;
            r.slv <= 1'b0;
            r.irq <= 1'b0;
            r.fail <= wss_pkg::FAIL_RST;
            r.vst <= wss_pkg::STAT_RST;
            r.est <= wss_pkg::STAT_RST;
            r.lvl <= wss_pkg::LVL_RST;
            r.sor <= wss_pkg::SOR_RST;
        end else begin
            r <= n;
        end
    end

    assign o_rst_timer = r.rst_tmr;
    assign o_rst_amplitude = r.rst_amp;
    assign o_rst_slicer = r.rst_sl;
    assign o_rst_chip_code = r.rst_cc;
    assign o_rst_baud = r.rst_cc;
    assign o_slicer_acq = r.st == wss_pkg::WSS_ACQ;
    assign o_slicer_valid = r.slv;
    assign o_search_busy = r.busy;
    assign o_irq = r.irq;
    assign o_search_failed_flag = r.fail;
    assign o_monitor_valid_status = r.vst;
    assign o_monitor_error_status = r.est;
    assign o_signal_level_status = r.lvl;
    assign o_sample_on_read = r.sor;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    start_resets_a: assert property (i_search_start |=>
        o_rst_timer && o_rst_amplitude && o_rst_chip_code && o_rst_baud)
        else $error("monitor resets missing after search start");

    slicer_reset_a: assert property (i_search_start |=>
        o_rst_slicer == ($past(i_slicer_preload_select) != wss_pkg::PRELOAD_NONE))
        else $error("slicer reset does not follow preload select");

    acq_hold_a: assert property (o_slicer_acq |-> o_rst_chip_code && o_rst_baud)
        else $error("checkers not held in reset during acquisition");

    slicer_valid_a: assert property (i_search_start && !i_init_acq_en |=>
        o_slicer_valid && !o_slicer_acq)
        else $error("slicer not valid at once without acquisition");

    search_end_a: assert property ($fell(o_search_busy) |-> o_irq && !o_sample_on_read)
        else $error("search end without interrupt or sample clear");

    fail_result_a: assert property (end_w |=> o_search_failed_flag == $past(any_fail))
        else $error("failed flag does not match decision");

    mode1_timer_a: assert property (!i_search_mode |-> !fail_w[wss_pkg::MON_TIMER])
        else $error("timer affects result in mode 1");

    success_err_a: assert property (o_irq && !o_search_failed_flag |->
        (o_monitor_error_status[4:0] & $past(i_monitor_select_mask[4:0])) == 5'h00)
        else $error("error bits set after successful search");

    read_sample_a: assert property (i_read_cmd && o_sample_on_read |=>
        o_signal_level_status == $past(i_signal_level))
        else $error("read command did not refresh snapshot");

    status_hold_a: assert property (!sample_w |=> $stable(o_monitor_valid_status)
        && $stable(o_monitor_error_status) && $stable(o_signal_level_status))
        else $error("snapshot changed without a sample event");

    timer_off_a: assert property ($rose(r.texp) |->
        $past(i_search_timeout_count) != wss_pkg::TIMEOUT_OFF)
        else $error("timer expired with timeout disabled");

    // Search end handshake toward the host
    irq_pulse_a: assert property (o_irq |=> !o_irq)
        else $error("interrupt longer than one cycle");

    irq_idle_a: assert property (o_irq |-> !o_search_busy)
        else $error("interrupt while search still busy");

    fail_set_a: assert property (end_w && any_fail |=> o_search_failed_flag)
        else $error("failed flag not set on failing search");

    pass_clear_a: assert property (end_w && !any_fail |=> !o_search_failed_flag)
        else $error("failed flag not cleared on passing search");

    // Decision terms per monitor
    unsel_terms_a: assert property (!i_monitor_select_mask[wss_pkg::MON_BAUD] |->
        pass_w[wss_pkg::MON_BAUD] && !fail_w[wss_pkg::MON_BAUD])
        else $error("unselected monitor affects decision");

    invalid_terms_a: assert property (i_monitor_select_mask[wss_pkg::MON_AMP] &&
        !i_mon_valid[wss_pkg::MON_AMP] |-> !pass_w[wss_pkg::MON_AMP] && !fail_w[wss_pkg::MON_AMP])
        else $error("invalid monitor gives a pass or fail term");

    mode2_timer_a: assert property (i_search_mode && r.texp |->
        fail_w[wss_pkg::MON_TIMER])
        else $error("expired timer ignored in mode 2");

    // Snapshot capture
    snap_together_a: assert property (sample_w |=>
        o_monitor_valid_status == $past(live_valid)
        && o_monitor_error_status == ($past(live_valid) & $past(live_error))
        && o_signal_level_status == $past(i_signal_level))
        else $error("status words not captured together");

    end_snap_a: assert property (end_w |=>
        o_signal_level_status == $past(i_signal_level))
        else $error("search end did not snapshot status");

    sor_end_a: assert property (end_w |=> !o_sample_on_read)
        else $error("sample-on-read not cleared at search end");

    sor_read_a: assert property (i_read_level_reg && !i_manual_sampling &&
        !end_w && !i_sor_write |=> o_sample_on_read)
        else $error("level read did not set sample-on-read");

    // Sequencing of timer, slicer and amplitude reset
    timer_start_a: assert property (i_search_start |=>
        r.tmr == 6'h00 && !r.texp)
        else $error("search timer not restarted at search start");

    acq_enter_a: assert property (i_search_start && i_init_acq_en |=>
        o_slicer_acq && !o_slicer_valid)
        else $error("acquisition not entered at search start");

    restart_a: assert property (r.st == wss_pkg::WSS_RUN && restart_w &&
        !i_search_start && !end_w |=> o_slicer_acq)
        else $error("chip timeout did not restart acquisition");

    rst_pulse_a: assert property (o_rst_amplitude && !i_search_start |=>
        !o_rst_amplitude)
        else $error("amplitude reset longer than one cycle");

endmodule

// ==== core/wss_pkg.sv ====
// Constants and types shared by the wakeup search control logic
package wss_pkg;

    // Monitor positions in the select mask and in the status words
    localparam int MON_W = 6;
    localparam int MON_LEVEL = 0;
    localparam int MON_AMP = 1;
    localparam int MON_CHIP = 2;
    localparam int MON_CODE = 3;
    localparam int MON_BAUD = 4;
    localparam int MON_TIMER = 5;
    localparam int LVL_W = 8;

    // Slicer preload select value meaning "no preload from init register"
    localparam logic [1:0] PRELOAD_NONE = 2'h0;

    // Initial acquisition length of the slicer, in bit ticks
    localparam logic [1:0] ACQ_BITS = 2'h2;

    // Bit ticks per search timeout unit (prescaler length)
    localparam logic [3:0] UNIT_BITS = 4'h4;

    // Timeout count that disables the search timer
    localparam logic [5:0] TIMEOUT_OFF = 6'h00;

    // Values after reset
    localparam logic SOR_RST = 1'b0;
    localparam logic FAIL_RST = 1'b0;
    localparam logic [MON_W-1:0] STAT_RST = 6'h00;
    localparam logic [LVL_W-1:0] LVL_RST = 8'h00;

    typedef enum logic [1:0] {
        WSS_IDLE,
        WSS_ACQ,
        WSS_RUN
    } wss_state_e_t;

    typedef struct packed {
        wss_state_e_t st;
        logic [1:0] bitcnt;
        logic [3:0] pre;
        logic [5:0] tmr;
        logic texp;
        logic busy;
        logic rst_tmr;
        logic rst_amp;
        logic rst_sl;
        logic rst_cc;
        logic slv;
        logic irq;
        logic fail;
        logic [MON_W-1:0] vst;
        logic [MON_W-1:0] est;
        logic [LVL_W-1:0] lvl;
        logic sor;
    } wss_regs_t;

endpackage

// ==== dv/wss_mon_model.sv ====
// Signal monitor stand-in: bit-rate ticks and monitor result levels
`timescale 1ns/1ps
module wss_mon_model (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [5:0] i_valid,
    input wire logic [5:0] i_error,
    output logic o_bit_tick,
    output logic [5:0] o_mon_valid,
    output logic [5:0] o_mon_error
);
    logic [1:0] div_r;
    // One bit tick every four clocks; results pass through one register stage
    always_ff @(posedge i_clock) begin
        div_r <= i_srst ? 2'h0 : div_r + 2'h1;
        o_bit_tick <= !i_srst && div_r == 2'h3;
        o_mon_valid <= i_srst ? 6'h00 : i_valid;
        o_mon_error <= i_srst ? 6'h00 : i_error;
    end
endmodule

// ==== dv/wss_search_tb_top.sv ====
// Self-checking testbench for the wakeup search control logic
`timescale 1ns/1ps
module wss_search_tb_top;
    logic clk = 0, srst = 1, st = 0, md = 0, acq = 0, rd = 0, rdl = 0, sw = 0, sd = 0, man = 0;
    logic cto = 0;
    logic [1:0] pre = 2'h0;
    logic [5:0] mask = 6'h00, tmo = 6'h00, val = 6'h00, err = 6'h00, mv, me, vs, es;
    logic [7:0] lvl = 8'h00, ls;
    logic tick, rt, ra, rs, rc, rb, sacq, sval, busy, irq, ff, sor;
    int failures = 0, checks = 0;

    always #5 clk = ~clk;

    wss_mon_model wss_mon_model_inst (.i_clock(clk), .i_srst(srst), .i_valid(val),
        .i_error(err), .o_bit_tick(tick), .o_mon_valid(mv), .o_mon_error(me));

    wss_search wss_search_inst (.i_clock(clk), .i_srst(srst), .i_search_start(st),
        .i_search_mode(md), .i_init_acq_en(acq), .i_slicer_preload_select(pre),
        .i_monitor_select_mask(mask), .i_search_timeout_count(tmo), .i_bit_tick(tick),
        .i_chip_timeout(cto), .i_mon_valid(mv), .i_mon_error(me), .i_signal_level(lvl),
        .i_read_cmd(rd), .i_read_level_reg(rdl), .i_sor_write(sw), .i_sor_wdata(sd),
        .i_manual_sampling(man), .o_rst_timer(rt), .o_rst_amplitude(ra),
        .o_rst_slicer(rs), .o_rst_chip_code(rc), .o_rst_baud(rb), .o_slicer_acq(sacq),
        .o_slicer_valid(sval), .o_search_busy(busy), .o_irq(irq),
        .o_search_failed_flag(ff), .o_monitor_valid_status(vs),
        .o_monitor_error_status(es), .o_signal_level_status(ls), .o_sample_on_read(sor));

    task automatic wrap_up;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Inputs change 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic start(input logic m, input logic [5:0] msk, input logic [5:0] t);
        md = m;
        mask = msk;
        tmo = t;
        st = 1;
        cyc(1);
        st = 0;
    endtask

    // Bounded wait for the end pulse, then the stored result
    task automatic wait_end(input int n, input logic exp_end, input logic exp_fail);
        logic seen;
        seen = 0;
        for (int i = 0; i < n && !seen; i++) begin
            cyc(1);
            seen = (irq === 1'b1);
        end
        chk({7'h00, seen}, {7'h00, exp_end});
        if (exp_end) chk({7'h00, ff}, {7'h00, exp_fail});
    endtask

    task automatic pulse_sor(input logic d);
        sw = 1;
        sd = d;
        cyc(1);
        sw = 0;
    endtask

    task automatic t_acq;
        acq = 1;
        pre = 2'h1;
        start(0, 6'h03, 6'h00);
        chk({1'b0, rt, ra, rs, rc, rb, sacq, busy}, 8'h7F);
        cyc(1);
        chk({3'h0, rt, ra, rs, rc, rb}, 8'h03);
        for (int i = 0; i < 20 && sval !== 1'b1; i++) cyc(1);
        chk({4'h0, sval, sacq, rc, rb}, 8'h08);
        pre = 2'h0;
        start(0, 6'h03, 6'h00);
        chk({5'h00, rs, rc, sacq}, 8'h03);
        acq = 0;
    endtask

    task automatic t_restart;
        val = 6'h00;
        acq = 1;
        pre = 2'h1;
        start(1, 6'h01, 6'h00);
        for (int i = 0; i < 20 && sval !== 1'b1; i++) cyc(1);
        cto = 1;
        cyc(1);
        cto = 0;
        chk({4'h0, sacq, sval, rs, rc}, 8'h0B);
        for (int i = 0; i < 20 && sval !== 1'b1; i++) cyc(1);
        md = 0;
        cto = 1;
        cyc(1);
        cto = 0;
        chk({4'h0, sacq, sval, rs, rc}, 8'h04);
        acq = 0;
        pre = 2'h0;
    endtask

    task automatic t_decide;
        val = 6'h3F;
        err = 6'h02;
        lvl = 8'h5A;
        start(0, 6'h01, 6'h00);
        chk({5'h00, sval, rs, rc}, 8'h05);
        wait_end(20, 1, 0);
        chk({3'h0, vs[4:0]}, 8'h1F);
        chk({3'h0, es[4:0]}, 8'h02);
        chk(ls, 8'h5A);
        start(0, 6'h03, 6'h00);
        wait_end(20, 1, 1);
        err = 6'h00;
        start(0, 6'h1F, 6'h00);
        wait_end(20, 1, 0);
        chk({3'h0, es[4:0]}, 8'h00);
        val = 6'h01;
        err = 6'h02;
        start(0, 6'h03, 6'h00);
        wait_end(30, 0, 0);
        err = 6'h00;
        val = 6'h3F;
        wait_end(10, 1, 0);
    endtask

    task automatic t_timer;
        val = 6'h00;
        start(0, 6'h03, 6'h01);
        wait_end(40, 0, 0);
        start(1, 6'h03, 6'h01);
        wait_end(40, 1, 1);
        start(1, 6'h03, 6'h00);
        wait_end(60, 0, 0);
    endtask

    task automatic t_snap;
        val = 6'h3F;
        lvl = 8'h11;
        pulse_sor(1);
        start(0, 6'h03, 6'h00);
        wait_end(20, 1, 0);
        chk({7'h00, sor}, 8'h00);
        chk(ls, 8'h11);
        lvl = 8'h22;
        rd = 1;
        cyc(1);
        rd = 0;
        cyc(1);
        chk(ls, 8'h11);
        pulse_sor(1);
        rd = 1;
        cyc(1);
        rd = 0;
        cyc(1);
        chk(ls, 8'h22);
        pulse_sor(0);
        rdl = 1;
        cyc(1);
        rdl = 0;
        cyc(1);
        chk({7'h00, sor}, 8'h01);
        man = 1;
        pulse_sor(0);
        rdl = 1;
        cyc(1);
        rdl = 0;
        cyc(1);
        chk({7'h00, sor}, 8'h00);
    endtask

    initial begin
        cyc(10);
        srst = 0;
        cyc(1);
        chk({4'h0, ff, sor, busy, irq}, 8'h00);
        t_acq();
        t_decide();
        t_timer();
        t_restart();
        t_snap();
        wrap_up();
    end

    // Whole run needs well under 1000 cycles
    initial begin
        #100000;
        failures++;
        wrap_up();
    end
endmodule
